// ---- rov_pkg.sv ----
// Constants, register map and state encoding for the residual overvoltage element
package rov_pkg;

  // Register bus geometry
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  // Register byte offsets
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] PICKUP_OFS = 8'h04;
  localparam logic [7:0] DELAY_OFS = 8'h08;
  localparam logic [7:0] STATE_OFS = 8'h0c;
  localparam logic [7:0] IRQ_STATUS_OFS = 8'h10;
  localparam logic [7:0] IRQ_ENABLE_OFS = 8'h14;
  localparam logic [7:0] IRQ_CLEAR_OFS = 8'h18;
  localparam logic [7:0] ELAPSED_OFS = 8'h1c;

  // Control register field positions
  localparam int CTRL_ENABLE_BIT = 0;
  localparam int CTRL_PICKUP_ONLY_BIT = 1;

  // State register field positions
  localparam int STATE_PICKUP_BIT = 0;
  localparam int STATE_TRIP_BIT = 1;
  localparam int STATE_INHIBIT_BIT = 2;
  localparam int STATE_OVER_BIT = 3;
  localparam int STATE_FSM_LSB = 4;

  // Interrupt event positions
  localparam int IRQ_W = 3;
  localparam int IRQ_PICKUP_RISE_BIT = 0;
  localparam int IRQ_TRIP_RISE_BIT = 1;
  localparam int IRQ_PICKUP_FALL_BIT = 2;

  // Setting ranges and reset values
  localparam logic [6:0] PICKUP_MIN = 7'h02;
  localparam logic [6:0] PICKUP_MAX = 7'h3c;
  localparam logic [6:0] PICKUP_RESET = 7'h1e;
  localparam logic [15:0] DELAY_MAX = 16'hea60;
  localparam logic [15:0] DELAY_RESET = 16'h0064;
  localparam logic ENABLE_RESET = 1'b1;
  localparam logic PICKUP_ONLY_RESET = 1'b0;
  localparam logic [IRQ_W-1:0] IRQ_ENABLE_RESET = 3'h0;

  // Magnitude format: percent of rated, fixed point
  localparam int MAG_FRAC_BITS = 8;
  localparam int MAG_W = 16;

  // Timing: delay resolution of one millisecond
  localparam int CLK_PERIOD_NS = 10;
  localparam int TICK_PERIOD_MS = 1;
  localparam int TICK_CYCLES = TICK_PERIOD_MS * 1000000 / CLK_PERIOD_NS;

  // Element state, Gray coded along idle -> picked up -> tripped
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_PICKED = 2'b01,
    ST_TRIPPED = 2'b11
  } elem_state_t;

endpackage

// ---- definite_timer.sv ----
// Millisecond definite-time delay counter
`timescale 1ns/10ps
module definite_timer
  import rov_pkg::*;
#(
  parameter int TICK_CYCLES_P = TICK_CYCLES
)
(
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire logic i_run,
  input wire logic [15:0] i_delay_ms,
  output logic o_expired,
  output logic [15:0] o_elapsed_ms
);

  localparam int PW = $clog2(TICK_CYCLES_P + 1);
  localparam logic [PW-1:0] TICK_LAST = PW'(TICK_CYCLES_P - 1);

  generate
    if (TICK_CYCLES_P < 1)
    begin : g_bad_tick
      $error("definite_timer: tick count must be at least one");
    end
  endgenerate

  typedef struct packed {
    logic [PW-1:0] prescale;
    logic [15:0] elapsed;
    logic expired;
  } timer_state_t;

  timer_state_t state_reg;
  timer_state_t state_next;

  // Prescaler and elapsed count, cleared whenever run drops
  always_comb
  begin
    state_next = state_reg;
    if (!i_run)
    begin
      state_next.prescale = '0;
      state_next.elapsed = 16'h0000;
      state_next.expired = 1'b0;
    end
    else
    begin
      if (state_reg.prescale == TICK_LAST)
      begin
        state_next.prescale = '0;
        if (state_reg.elapsed != DELAY_MAX)
        begin
          state_next.elapsed = state_reg.elapsed + 16'h0001;
        end
      end
      else
      begin
        state_next.prescale = state_reg.prescale + PW'(1);
      end
      state_next.expired = (state_reg.elapsed >= i_delay_ms);
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      state_reg <= '0;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  assign o_expired = state_reg.expired;
  assign o_elapsed_ms = state_reg.elapsed;

endmodule

// ---- residual_overvoltage_definite_time.sv ----
// Definite-time residual overvoltage protection element with register port
`timescale 1ns/10ps
module residual_overvoltage_definite_time
  import rov_pkg::*;
#(
  parameter int TICK_CYCLES_P = TICK_CYCLES,
  parameter int MAG_W_P = MAG_W
)
(
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire logic [MAG_W_P-1:0] i_residual_fundamental_rms,
  input wire logic i_inhibit_input,
  input wire logic [ADDR_W-1:0] i_addr,
  input wire logic [DATA_W-1:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [DATA_W-1:0] o_rdata,
  output logic o_general_pickup_out,
  output logic o_general_trip_out,
  output logic o_irq
);

  generate
    if (MAG_W_P < MAG_FRAC_BITS + 7)
    begin : g_bad_mag
      $error("residual_overvoltage_definite_time: magnitude too narrow for pickup range");
    end
    if (TICK_CYCLES_P < 1)
    begin : g_bad_tick
      $error("residual_overvoltage_definite_time: tick count must be at least one");
    end
  endgenerate

  typedef struct packed {
    logic element_enable_setting;
    logic pickup_only_setting;
    logic [6:0] pickup_level_setting;
    logic [15:0] definite_delay_setting;
    logic [IRQ_W-1:0] irq_status;
    logic [IRQ_W-1:0] irq_enable;
    elem_state_t fsm;
    logic pickup_status;
    logic trip_status;
    logic [DATA_W-1:0] rdata;
    logic irq;
  } elem_regs_t;

  elem_regs_t state_reg;
  elem_regs_t state_next;

  logic timer_expired;
  logic [15:0] timer_elapsed;
  logic over_level;
  logic element_active;
  logic pickup_now;
  logic trip_now;
  logic [IRQ_W-1:0] irq_events;
  logic [MAG_W_P-1:0] pickup_scaled;

  // Address match used by both the write and read paths
  function automatic logic hit(input logic [ADDR_W-1:0] addr, input logic [ADDR_W-1:0] ofs);
    hit = (addr == ofs);
  endfunction

  // Pickup percent moved into the magnitude fixed-point format
  assign pickup_scaled = MAG_W_P'({state_reg.pickup_level_setting, {MAG_FRAC_BITS{1'b0}}});

  // Level comparison against the fundamental RMS magnitude
  assign over_level = (i_residual_fundamental_rms > pickup_scaled);

  // Element is live only when switched on and not inhibited
  assign element_active = state_reg.element_enable_setting && !i_inhibit_input;

  // Start and trip decisions
  assign pickup_now = element_active && over_level;
  assign trip_now = pickup_now && timer_expired && !state_reg.pickup_only_setting;

  // Delay timer, held in clear whenever start is absent
  definite_timer #(
    .TICK_CYCLES_P(TICK_CYCLES_P)
  ) u_timer (
    .i_clk(i_clk),
    .i_arst_n(i_arst_n),
    .i_run(pickup_now),
    .i_delay_ms(state_reg.definite_delay_setting),
    .o_expired(timer_expired),
    .o_elapsed_ms(timer_elapsed)
  );

  // Interrupt events from output edges
  always_comb
  begin
    irq_events = '0;
    irq_events[IRQ_PICKUP_RISE_BIT] = pickup_now && !state_reg.pickup_status;
    irq_events[IRQ_TRIP_RISE_BIT] = trip_now && !state_reg.trip_status;
    irq_events[IRQ_PICKUP_FALL_BIT] = !pickup_now && state_reg.pickup_status;
  end

  // Next state of the whole element
  always_comb
  begin
    state_next = state_reg;

    // Settings writes; out-of-range pickup ignored, long delay clamped
    if (i_wr)
    begin
      if (hit(i_addr, CTRL_OFS))
      begin
        state_next.element_enable_setting = i_wdata[CTRL_ENABLE_BIT];
        state_next.pickup_only_setting = i_wdata[CTRL_PICKUP_ONLY_BIT];
      end
      else if (hit(i_addr, PICKUP_OFS))
      begin
        if ((i_wdata >= DATA_W'(PICKUP_MIN)) && (i_wdata <= DATA_W'(PICKUP_MAX)))
        begin
          state_next.pickup_level_setting = i_wdata[6:0];
        end
      end
      else if (hit(i_addr, DELAY_OFS))
      begin
        if (i_wdata > DATA_W'(DELAY_MAX))
        begin
          state_next.definite_delay_setting = DELAY_MAX;
        end
        else
        begin
          state_next.definite_delay_setting = i_wdata[15:0];
        end
      end
      else if (hit(i_addr, IRQ_ENABLE_OFS))
      begin
        state_next.irq_enable = i_wdata[IRQ_W-1:0];
      end
    end

    // Sticky events; a set in the clearing cycle wins
    if (i_wr && hit(i_addr, IRQ_CLEAR_OFS))
    begin
      state_next.irq_status = (state_reg.irq_status & ~i_wdata[IRQ_W-1:0]) | irq_events;
    end
    else
    begin
      state_next.irq_status = state_reg.irq_status | irq_events;
    end

    // Decision stage outputs
    state_next.pickup_status = pickup_now;
    state_next.trip_status = trip_now;

    // Element state follows the decisions
    case (state_reg.fsm)
      ST_IDLE:
      begin
        if (pickup_now)
        begin
          state_next.fsm = ST_PICKED;
        end
      end
      ST_PICKED:
      begin
        if (!pickup_now)
        begin
          state_next.fsm = ST_IDLE;
        end
        else if (trip_now)
        begin
          state_next.fsm = ST_TRIPPED;
        end
      end
      ST_TRIPPED:
      begin
        if (!pickup_now)
        begin
          state_next.fsm = ST_IDLE;
        end
        else if (!trip_now)
        begin
          state_next.fsm = ST_PICKED;
        end
      end
      default:
      begin
        state_next.fsm = ST_IDLE;
      end
    endcase

    // Read data valid only in the cycle after the strobe
    state_next.rdata = '0;
    if (i_rd)
    begin
      if (hit(i_addr, CTRL_OFS))
      begin
        state_next.rdata[CTRL_ENABLE_BIT] = state_reg.element_enable_setting;
        state_next.rdata[CTRL_PICKUP_ONLY_BIT] = state_reg.pickup_only_setting;
      end
      else if (hit(i_addr, PICKUP_OFS))
      begin
        state_next.rdata[6:0] = state_reg.pickup_level_setting;
      end
      else if (hit(i_addr, DELAY_OFS))
      begin
        state_next.rdata[15:0] = state_reg.definite_delay_setting;
      end
      else if (hit(i_addr, STATE_OFS))
      begin
        state_next.rdata[STATE_PICKUP_BIT] = state_reg.pickup_status;
        state_next.rdata[STATE_TRIP_BIT] = state_reg.trip_status;
        state_next.rdata[STATE_INHIBIT_BIT] = i_inhibit_input;
        state_next.rdata[STATE_OVER_BIT] = over_level;
        state_next.rdata[STATE_FSM_LSB +: 2] = state_reg.fsm;
      end
      else if (hit(i_addr, IRQ_STATUS_OFS))
      begin
        state_next.rdata[IRQ_W-1:0] = state_reg.irq_status;
      end
      else if (hit(i_addr, IRQ_ENABLE_OFS))
      begin
        state_next.rdata[IRQ_W-1:0] = state_reg.irq_enable;
      end
      else if (hit(i_addr, ELAPSED_OFS))
      begin
        state_next.rdata[15:0] = timer_elapsed;
      end
    end

    // Level interrupt from enabled sticky bits
    state_next.irq = |(state_next.irq_status & state_next.irq_enable);
  end

  // State register with reset values
  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      state_reg.element_enable_setting <= ENABLE_RESET;
      state_reg.pickup_only_setting <= PICKUP_ONLY_RESET;
      state_reg.pickup_level_setting <= PICKUP_RESET;
      state_reg.definite_delay_setting <= DELAY_RESET;
      state_reg.irq_status <= '0;
      state_reg.irq_enable <= IRQ_ENABLE_RESET;
      state_reg.fsm <= ST_IDLE;
      state_reg.pickup_status <= 1'b0;
      state_reg.trip_status <= 1'b0;
      state_reg.rdata <= '0;
      state_reg.irq <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  // Outputs straight from flip-flops
  assign o_general_pickup_out = state_reg.pickup_status;
  assign o_general_trip_out = state_reg.trip_status;
  assign o_rdata = state_reg.rdata;
  assign o_irq = state_reg.irq;

endmodule

// ---- rms_source.sv ----
// Upstream residual voltage magnitude source model
`timescale 1ns/10ps
module rms_source
  import rov_pkg::*;
(
  input wire logic [6:0] i_pct,
  input wire logic [7:0] i_frac,
  output logic [MAG_W-1:0] o_rms
);
  // Fundamental RMS of residual voltage, percent in Q8.8
  assign o_rms = {1'b0, i_pct, i_frac};
endmodule

// ---- rov_properties.sv ----
// Port-level properties of the residual overvoltage element
`timescale 1ns/10ps
module rov_checker
  import rov_pkg::*;
#(
  parameter int TICK_CYCLES_P = TICK_CYCLES,
  parameter int MAG_W_P = MAG_W
)
(
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire logic [MAG_W_P-1:0] i_residual_fundamental_rms,
  input wire logic i_inhibit_input,
  input wire logic [ADDR_W-1:0] i_addr,
  input wire logic [DATA_W-1:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [DATA_W-1:0] o_rdata,
  input wire logic o_general_pickup_out,
  input wire logic o_general_trip_out,
  input wire logic o_irq
);
  logic [2:0] cfg_reg;
  // Shadow of enable, pickup-only and start irq enable
  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      cfg_reg <= 3'h1;
    end
    else if (i_wr && i_addr == CTRL_OFS)
    begin
      cfg_reg[0] <= i_wdata[CTRL_ENABLE_BIT];
      cfg_reg[1] <= i_wdata[CTRL_PICKUP_ONLY_BIT];
    end
    else if (i_wr && i_addr == IRQ_ENABLE_OFS)
    begin
      cfg_reg[2] <= i_wdata[IRQ_PICKUP_RISE_BIT];
    end
  end

  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_arst_n);

  a_trip_needs_pickup: assert property (o_general_trip_out |-> o_general_pickup_out)
    else $error("trip without pickup");
  a_drop_clears_trip: assert property ($fell(o_general_pickup_out) |-> !o_general_trip_out)
    else $error("trip kept after pickup drop");
  a_trip_after_pickup: assert property ($rose(o_general_trip_out) |-> $past(o_general_pickup_out))
    else $error("trip rose without prior pickup");
  a_inhibit_quiet: assert property (i_inhibit_input |=> !o_general_pickup_out && !o_general_trip_out)
    else $error("outputs active under inhibit");
  a_off_quiet: assert property (!cfg_reg[0] |=> !o_general_pickup_out && !o_general_trip_out)
    else $error("outputs active while disabled");
  a_only_no_trip: assert property (cfg_reg[1] |=> !o_general_trip_out)
    else $error("trip in pickup-only mode");
  a_low_quiet: assert property (i_residual_fundamental_rms <= {PICKUP_MIN, 8'h00} |=> !o_general_pickup_out)
    else $error("pickup below lowest setting");
  a_pickup_cause: assert property ($rose(o_general_pickup_out) |-> !$past(i_inhibit_input))
    else $error("pickup rose after inhibit");
  a_irq_on_start: assert property ($rose(o_general_pickup_out) && cfg_reg[2] |-> o_irq)
    else $error("no interrupt on enabled pickup");
  a_rdata_idle: assert property (!i_rd |=> o_rdata == '0)
    else $error("read data outside read slot");

  c_pickup: cover property ($rose(o_general_pickup_out));
  c_trip: cover property ($rose(o_general_trip_out));
  c_irq: cover property ($rose(o_irq));
endmodule

bind residual_overvoltage_definite_time rov_checker #(.TICK_CYCLES_P(TICK_CYCLES_P), .MAG_W_P(MAG_W_P)) u_chk (
  .i_clk(i_clk), .i_arst_n(i_arst_n), .i_residual_fundamental_rms(i_residual_fundamental_rms),
  .i_inhibit_input(i_inhibit_input), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
  .o_rdata(o_rdata), .o_general_pickup_out(o_general_pickup_out),
  .o_general_trip_out(o_general_trip_out), .o_irq(o_irq));

// ---- residual_overvoltage_definite_time_test.sv ----
// Self-checking bench for the residual overvoltage element
`timescale 1ns/10ps
module residual_overvoltage_definite_time_test
  import rov_pkg::*;
();
  localparam int TICK = 4;
  localparam int TRIP_CYC = 2 + 2 * TICK;
  logic i_clk = 1'b0;
  logic i_arst_n = 1'b0;
  logic inh = 1'b0;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic [ADDR_W-1:0] i_addr = '0;
  logic [DATA_W-1:0] i_wdata = '0;
  logic [6:0] pct = '0;
  logic [7:0] frac = '0;
  logic [MAG_W-1:0] rms;
  logic [DATA_W-1:0] o_rdata;
  logic pick, trip, o_irq;
  int error_cnt = 0;
  int checks_done = 0;
  int cycles = 0;

  // Free-running clock
  always #5 i_clk = ~i_clk;

  rms_source u_src (.i_pct(pct), .i_frac(frac), .o_rms(rms));
  residual_overvoltage_definite_time #(.TICK_CYCLES_P(TICK)) u_dut (.i_clk(i_clk), .i_arst_n(i_arst_n),
    .i_residual_fundamental_rms(rms), .i_inhibit_input(inh), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_general_pickup_out(pick),
    .o_general_trip_out(trip), .o_irq(o_irq));

  task complete_run();
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask

  task rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge i_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1 check(o_rdata, exp);
  endtask

  task drive(input logic [6:0] p, input logic [7:0] f, input logic b, input int n);
    @(posedge i_clk);
    pct <= p;
    frac <= f;
    inh <= b;
    repeat (n) @(posedge i_clk);
    #1;
  endtask

  // Counts edges from a just-over level to trip
  task time_trip(input int exp);
    int n;
    n = 0;
    drive(7'h1e, 8'h01, 1'b0, 0);
    while (trip !== 1'b1 && n < 200)
    begin
      @(posedge i_clk);
      n++;
      #1;
    end
    check(n, exp);
  endtask

  // Hang guard
  always @(posedge i_clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 5000)
    begin
      error_cnt++;
      complete_run();
    end
  end

  initial
  begin
    repeat (4) @(posedge i_clk);
    i_arst_n <= 1'b1;
    rd(CTRL_OFS, 32'h1);
    rd(PICKUP_OFS, 32'h1e);
    rd(DELAY_OFS, 32'h64);
    rd(IRQ_ENABLE_OFS, 32'h0);
    rd(8'h20, 32'h0);
    wr(PICKUP_OFS, 32'h3d);
    rd(PICKUP_OFS, 32'h1e);
    wr(DELAY_OFS, 32'h11170);
    rd(DELAY_OFS, 32'hea60);
    wr(DELAY_OFS, 32'h2);
    $display("test registers done");
    drive(7'h1e, 8'h00, 1'b0, 20);
    check(pick, 1'b0);
    time_trip(TRIP_CYC);
    check({pick, trip}, 2'h3);
    rd(STATE_OFS, 32'h3b);
    rd(ELAPSED_OFS, 32'h3);
    drive(7'h1e, 8'h00, 1'b0, 1);
    check({pick, trip}, 2'h0);
    drive(7'h3c, 8'h00, 1'b0, TRIP_CYC - 2);
    drive(7'h3c, 8'h00, 1'b1, 1);
    check({pick, trip}, 2'h0);
    time_trip(TRIP_CYC);
    $display("test timing done");
    wr(CTRL_OFS, 32'h3);
    drive(7'h3c, 8'h00, 1'b0, 3 * TRIP_CYC);
    check({pick, trip}, 2'h2);
    wr(CTRL_OFS, 32'h0);
    drive(7'h3c, 8'h00, 1'b0, 3);
    check({pick, trip}, 2'h0);
    wr(CTRL_OFS, 32'h1);
    drive(7'h00, 8'h00, 1'b0, 2);
    $display("test modes done");
    rd(IRQ_STATUS_OFS, 32'h7);
    check(o_irq, 1'b0);
    wr(IRQ_ENABLE_OFS, 32'h1);
    drive(7'h00, 8'h00, 1'b0, 2);
    check(o_irq, 1'b1);
    wr(IRQ_CLEAR_OFS, 32'h7);
    drive(7'h00, 8'h00, 1'b0, 2);
    check(o_irq, 1'b0);
    rd(IRQ_STATUS_OFS, 32'h0);
    time_trip(TRIP_CYC);
    check(o_irq, 1'b1);
    $display("test interrupts done");
    complete_run();
  end
endmodule
